//--- rtl/fbi_cfg.svh
// Constants of the flash block interface: geometry, codes, timing
`ifndef FBI_CFG_SVH
`define FBI_CFG_SVH
`define FBI_SECTORS     64
`define FBI_PAGES       33
`define FBI_BLKS        9
`define FBI_PAGE_CNT    2112
`define FBI_BLK_CNT     19008
`define FBI_SPARE_PG    6'h20
`define FBI_LAST_LPG    6'h1f
`define FBI_LAST_SECT   6'h3f
`define FBI_AUX_BLK     4'h8
`define FBI_LAST_DBLK   4'h7
`define FBI_ST_OK       2'h0
`define FBI_ST_SGL      2'h1
`define FBI_ST_DBL      2'h2
`define FBI_ST_FAIL     2'h3
`define FBI_FETCH_CYC   3'h3
`define FBI_BUSY_MAX    4'h9
`define FBI_WR_LIMIT    14'h03e8
`endif

//--- rtl/fbi_pkg.sv
// Types and shared functions of the flash block interface
package fbi_pkg;
`include "fbi_cfg.svh"
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_FETCH, ST_COPY, ST_PROG, ST_ERASE,
		ST_OUT} fbi_state_t;
	typedef enum logic [2:0] {CM_NONE, CM_READ, CM_WRITE, CM_PROG, CM_ERASE, CM_UNLOCK,
		CM_DROP} fbi_cmd_t;
	typedef enum logic [1:0] {FP_DEMAND, FP_PREF, FP_COPY} fbi_purp_t;
	typedef struct packed {
		logic [5:0] sect;
		logic [5:0] page;
		logic [3:0] blk;
	} fbi_addr_t;
	typedef struct packed {
		fbi_state_t        st;
		fbi_cmd_t          cmd;
		fbi_addr_t         ra;
		logic [1:0]        rw;
		logic [31:0]       wd;
		logic              r_seq;
		logic              r_m6;
		logic              r_lock;
		logic              f_act;
		fbi_purp_t         f_pur;
		fbi_addr_t         fa;
		logic [2:0]        fcnt;
		logic [127:0]      bb;
		fbi_addr_t         bba;
		logic              bbv;
		logic [1:0]        bbs;
		logic [127:0]      pf;
		fbi_addr_t         pfa;
		logic              pfv;
		logic [1:0]        pfs;
		logic              pfw;
		logic [8:0][127:0] pb;
		logic [5:0]        pbs;
		logic [5:0]        pbp;
		logic              pbv;
		logic              pbd;
		logic [3:0]        uc;
		logic [1:0]        acc;
		logic              wp;
		logic [31:0]       rd;
		logic              busy;
		logic [1:0]        stat;
	} fbi_st_t;

	function automatic logic [11:0] fbi_pg_idx(input fbi_addr_t a);
		return 12'(a.sect) * 12'h021 + 12'(a.page);
	endfunction

	function automatic logic [14:0] fbi_blk_idx(input fbi_addr_t a);
		return 15'(fbi_pg_idx(a)) * 15'h0009 + 15'(a.blk);
	endfunction

	function automatic logic [31:0] fbi_word(input logic [127:0] b, input logic [1:0] w);
		return b[32 * w +: 32];
	endfunction

	// Hamming over positions 1..136 plus an overall parity bit
	function automatic logic [8:0] fbi_ecc_enc(input logic [127:0] d);
		logic [7:0] p;
		int         k;
		p = 8'h00;
		k = 0;
		for (int pos = 1; pos < 137; pos++)
			if ((pos & (pos - 1)) != 0)
			begin
				if (d[k])
					p = p ^ pos[7:0];
				k++;
			end
		return {(^d) ^ (^p), p};
	endfunction
endpackage

//--- rtl/fbi_ecc_dec.sv
// Single-error correcting, double-error detecting check of one block
`timescale 1ns/1ps
module fbi_ecc_dec
	import fbi_pkg::*;
(
	input  wire logic [127:0] i_data,
	input  wire logic [8:0]   i_chk,
	output logic      [127:0] o_data,
	output logic              o_single,
	output logic              o_double
);
	logic [8:0] enc;
	logic [7:0] syn;
	logic       par;
	int         k;

	always_comb
	begin
		enc = fbi_ecc_enc(i_data);
		syn = enc[7:0] ^ i_chk[7:0];
		par = (^i_data) ^ (^i_chk);
		o_data = i_data;
		k = 0;
		// A zero syndrome with bad parity is the parity bit itself
		for (int pos = 1; pos < 137; pos++)
			if ((pos & (pos - 1)) != 0)
			begin
				if (par && syn == pos[7:0])
					o_data[k] = ~i_data[k];
				k++;
			end
		o_single = par;
		o_double = !par && syn != 8'h00;
	end
endmodule // fbi_ecc_dec

//--- rtl/fbi_next_addr.sv
// Look-ahead address for sequential prefetch
`timescale 1ns/1ps
`include "fbi_cfg.svh"
module fbi_next_addr
	import fbi_pkg::*;
(
	input  wire logic [5:0] i_sect,
	input  wire logic [5:0] i_page,
	input  wire logic [3:0] i_blk,
	output logic      [5:0] o_sect,
	output logic      [5:0] o_page,
	output logic      [3:0] o_blk
);
	always_comb
	begin
		o_sect = i_sect;
		o_page = i_page;
		o_blk  = i_blk + 4'h1;
		// Sector field wraps 63 to 0 by its width
		if (i_page == `FBI_SPARE_PG)
		begin
			o_sect = i_sect + 6'h01;
			o_blk  = i_blk == `FBI_AUX_BLK ? `FBI_AUX_BLK : 4'h0;
		end
		else if (i_blk == `FBI_AUX_BLK || i_blk == `FBI_LAST_DBLK)
		begin
			o_blk  = i_blk == `FBI_AUX_BLK ? `FBI_AUX_BLK : 4'h0;
			o_page = i_page == `FBI_LAST_LPG ? 6'h00 : i_page + 6'h01;
			if (i_page == `FBI_LAST_LPG)
				o_sect = i_sect + 6'h01;
		end
	end
endmodule // fbi_next_addr

//--- rtl/fbi_flash_if.sv
// Flash block interface: page buffer, block buffer, ECC, prefetch, status
`timescale 1ns/1ps
`include "fbi_cfg.svh"
module fbi_flash_if
	import fbi_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic [5:0]  i_sector,
	input  wire logic [5:0]  i_page,
	input  wire logic [2:0]  i_block,
	input  wire logic [1:0]  i_word,
	input  wire logic        i_spare_page_sel,
	input  wire logic        i_extra_block_sel,
	input  wire logic        i_seq_prefetch_sel,
	input  wire logic        i_six_cycle_mode,
	input  wire logic        i_read_req,
	input  wire logic        i_buf_write_req,
	input  wire logic [31:0] i_write_word_in,
	input  wire logic        i_prog_req,
	input  wire logic        i_page_lock_set,
	input  wire logic        i_page_erase_req,
	input  wire logic        i_page_unlock_req,
	input  wire logic        i_buffer_drop_req,
	output logic      [31:0] o_rd_data,
	output logic             o_busy,
	output logic      [1:0]  o_status
);
	// ****************************************
	// Reset release and storage
	// ****************************************
	logic              rst_meta_q;
	logic              rst_n;
	fbi_st_t           s_q;
	fbi_st_t           s_d;
	logic [136:0]      flash_store [0:`FBI_BLK_CNT-1];
	logic [13:0]       wcnt_mem [0:`FBI_PAGE_CNT-1];
	logic              lock_mem [0:`FBI_PAGE_CNT-1];
	logic [136:0]      raw_q;
	logic              mem_we;
	logic [14:0]       mem_idx;
	logic [136:0]      mem_wd;
	logic              cnt_we;
	logic [11:0]       cnt_idx;
	logic              lk_val;
	fbi_addr_t         a_in;
	fbi_addr_t         nxt;
	fbi_cmd_t          cmd_in;
	logic [127:0]      dec_d;
	logic              dec_sgl;
	logic              dec_dbl;
	logic [1:0]        dec_stat;
	logic              fdone;
	logic              dlv;
	logic [127:0]      dlv_d;
	logic [1:0]        dlv_s;
	logic              same_pg;
	logic              disp;
	logic [3:0]        bsy_cnt;

	always_ff @(posedge i_clk or negedge i_arst_n)
		if (!i_arst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end

	// Array word read one cycle behind the fetch address
	always_ff @(posedge i_clk)
	begin
		if (mem_we)
			flash_store[mem_idx] <= mem_wd;
		raw_q <= flash_store[fbi_blk_idx(s_q.fa)];
	end

	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
			for (int i = 0; i < `FBI_PAGE_CNT; i++)
			begin
				wcnt_mem[i] <= 14'h0000;
				lock_mem[i] <= 1'b0;
			end
		else if (cnt_we)
		begin
			// Saturating so a worn page never wraps back to fresh; only reset clears the count
			if (wcnt_mem[cnt_idx] != 14'h3fff)
				wcnt_mem[cnt_idx] <= wcnt_mem[cnt_idx] + 14'h0001;
			lock_mem[cnt_idx] <= lk_val;
		end

	// ****************************************
	// Check bits and look-ahead address
	// ****************************************
	fbi_ecc_dec u_ecc (
		.i_data   (raw_q[127:0]),
		.i_chk    (raw_q[136:128]),
		.o_data   (dec_d),
		.o_single (dec_sgl),
		.o_double (dec_dbl)
	);

	fbi_next_addr u_next (
		.i_sect (s_q.bba.sect),
		.i_page (s_q.bba.page),
		.i_blk  (s_q.bba.blk),
		.o_sect (nxt.sect),
		.o_page (nxt.page),
		.o_blk  (nxt.blk)
	);

	assign dec_stat = dec_dbl ? `FBI_ST_DBL : (dec_sgl ? `FBI_ST_SGL : `FBI_ST_OK);
	assign fdone    = s_q.f_act && s_q.fcnt == `FBI_FETCH_CYC - 3'h1;
	assign same_pg  = s_q.pbv && s_q.pbs == s_q.ra.sect && s_q.pbp == s_q.ra.page;
	assign disp     = s_q.st == ST_WAIT && !s_q.f_act;

	// ****************************************
	// Command capture and sequencing
	// ****************************************
	always_comb
	begin
		a_in.sect = i_sector;
		a_in.page = i_spare_page_sel ? `FBI_SPARE_PG : i_page;
		a_in.blk  = i_extra_block_sel ? `FBI_AUX_BLK : {1'b0, i_block};
		if (i_read_req)
			cmd_in = CM_READ;
		else if (i_buf_write_req)
			cmd_in = CM_WRITE;
		else if (i_prog_req)
			cmd_in = CM_PROG;
		else if (i_page_erase_req)
			cmd_in = CM_ERASE;
		else if (i_page_unlock_req)
			cmd_in = CM_UNLOCK;
		else if (i_buffer_drop_req)
			cmd_in = CM_DROP;
		else
			cmd_in = CM_NONE;
	end

	always_comb
	begin
		s_d     = s_q;
		mem_we  = 1'b0;
		mem_idx = 15'h0000;
		mem_wd  = 137'h0;
		cnt_we  = 1'b0;
		cnt_idx = fbi_pg_idx(s_q.ra);
		lk_val  = lock_mem[fbi_pg_idx(s_q.ra)];
		dlv     = 1'b0;
		dlv_d   = s_q.bb;
		dlv_s   = `FBI_ST_OK;
		if (s_q.f_act)
			s_d.fcnt = s_q.fcnt + 3'h1;
		if (fdone)
			s_d.f_act = 1'b0;
		if (fdone && s_q.f_pur == FP_PREF)
		begin
			s_d.pf  = dec_d;
			s_d.pfa = s_q.fa;
			s_d.pfv = 1'b1;
			s_d.pfs = dec_stat;
		end
		case (s_q.st)
			ST_IDLE:
				if (cmd_in != CM_NONE)
				begin
					s_d.cmd    = cmd_in;
					s_d.ra     = a_in;
					s_d.rw     = i_word;
					s_d.wd     = i_write_word_in;
					s_d.r_seq  = i_seq_prefetch_sel;
					s_d.r_m6   = i_six_cycle_mode;
					s_d.r_lock = i_page_lock_set;
					s_d.busy   = 1'b1;
					s_d.st     = ST_WAIT;
				end
				else if (s_q.pfw && !s_q.f_act)
				begin
					s_d.pfw   = 1'b0;
					s_d.pfv   = 1'b0;
					s_d.f_act = 1'b1;
					s_d.f_pur = FP_PREF;
					s_d.fa    = nxt;
					s_d.fcnt  = 3'h0;
				end
			ST_WAIT:
				// Busy holds while a running prefetch drains
				if (!s_q.f_act)
				begin
					s_d.st   = ST_IDLE;
					s_d.busy = 1'b0;
					case (s_q.cmd)
						CM_READ:
							if (s_q.bbv && s_q.bba == s_q.ra)
							begin
								dlv   = 1'b1;
								dlv_s = s_q.bbs;
							end
							else if (s_q.pfv && s_q.pfa == s_q.ra)
							begin
								dlv   = 1'b1;
								dlv_d = s_q.pf;
								dlv_s = s_q.pfs;
							end
							else
							begin
								s_d.f_act = 1'b1;
								s_d.f_pur = FP_DEMAND;
								s_d.fa    = s_q.ra;
								s_d.fcnt  = 3'h0;
								s_d.busy  = 1'b1;
								s_d.st    = ST_FETCH;
							end
						CM_WRITE:
							if (same_pg)
							begin
								s_d.pb[s_q.ra.blk][32 * s_q.rw +: 32] = s_q.wd;
								s_d.pbd  = 1'b1;
								s_d.stat = `FBI_ST_OK;
							end
							else if (s_q.pbv && s_q.pbd)
								s_d.stat = `FBI_ST_FAIL;
							else if (lock_mem[fbi_pg_idx(s_q.ra)])
								s_d.stat = `FBI_ST_SGL;
							else
							begin
								// Clean buffer on another page reloads first
								s_d.wp    = 1'b1;
								s_d.uc    = 4'h0;
								s_d.acc   = `FBI_ST_OK;
								s_d.f_act = 1'b1;
								s_d.f_pur = FP_COPY;
								s_d.fa    = {s_q.ra.sect, s_q.ra.page, 4'h0};
								s_d.fcnt  = 3'h0;
								s_d.busy  = 1'b1;
								s_d.st    = ST_COPY;
							end
						CM_PROG:
							if (!s_q.pbv || !s_q.pbd)
								s_d.stat = `FBI_ST_SGL;
							else if (wcnt_mem[fbi_pg_idx({s_q.pbs, s_q.pbp, 4'h0})]
								>= `FBI_WR_LIMIT)
								s_d.stat = `FBI_ST_FAIL;
							else
							begin
								s_d.uc   = 4'h0;
								s_d.busy = 1'b1;
								s_d.st   = ST_PROG;
							end
						CM_ERASE:
							if (lock_mem[fbi_pg_idx(s_q.ra)])
								s_d.stat = `FBI_ST_SGL;
							else if (wcnt_mem[fbi_pg_idx(s_q.ra)] >= `FBI_WR_LIMIT)
								s_d.stat = `FBI_ST_FAIL;
							else
							begin
								s_d.uc   = 4'h0;
								s_d.busy = 1'b1;
								s_d.st   = ST_ERASE;
							end
						CM_UNLOCK:
						begin
							s_d.wp    = 1'b0;
							s_d.uc    = 4'h0;
							s_d.acc   = `FBI_ST_OK;
							s_d.f_act = 1'b1;
							s_d.f_pur = FP_COPY;
							s_d.fa    = {s_q.ra.sect, s_q.ra.page, 4'h0};
							s_d.fcnt  = 3'h0;
							s_d.busy  = 1'b1;
							s_d.st    = ST_COPY;
						end
						CM_DROP:
						begin
							s_d.pbv  = 1'b0;
							s_d.pbd  = 1'b0;
							s_d.stat = `FBI_ST_OK;
						end
						default:
							s_d.stat = `FBI_ST_OK;
					endcase
				end
			ST_FETCH:
				if (fdone)
				begin
					dlv   = 1'b1;
					dlv_d = dec_d;
					dlv_s = dec_stat;
				end
			ST_COPY:
				if (fdone)
				begin
					s_d.pb[s_q.uc] = dec_d;
					s_d.acc        = dec_stat > s_q.acc ? dec_stat : s_q.acc;
					if (s_q.uc == `FBI_AUX_BLK)
					begin
						s_d.pbv  = 1'b1;
						s_d.pbd  = s_q.wp;
						s_d.pbs  = s_q.ra.sect;
						s_d.pbp  = s_q.ra.page;
						s_d.stat = s_d.acc;
						if (s_q.wp)
							s_d.pb[s_q.ra.blk][32 * s_q.rw +: 32] = s_q.wd;
						s_d.busy = 1'b0;
						s_d.st   = ST_IDLE;
					end
					else
					begin
						s_d.uc     = s_q.uc + 4'h1;
						s_d.f_act  = 1'b1;
						s_d.fa.blk = s_q.uc + 4'h1;
						s_d.fcnt   = 3'h0;
					end
				end
			ST_PROG, ST_ERASE:
			begin
				mem_we = 1'b1;
				if (s_q.st == ST_PROG)
				begin
					mem_idx = fbi_blk_idx({s_q.pbs, s_q.pbp, s_q.uc});
					mem_wd  = {fbi_ecc_enc(s_q.pb[s_q.uc]), s_q.pb[s_q.uc]};
					cnt_idx = fbi_pg_idx({s_q.pbs, s_q.pbp, 4'h0});
					lk_val  = s_q.r_lock;
				end
				else
				begin
					mem_idx = fbi_blk_idx({s_q.ra.sect, s_q.ra.page, s_q.uc});
					mem_wd  = {fbi_ecc_enc(128'h0), 128'h0};
				end
				s_d.uc = s_q.uc + 4'h1;
				if (s_q.uc == `FBI_AUX_BLK)
				begin
					cnt_we = 1'b1;
					// Cached copies of the array may now be stale
					s_d.bbv  = 1'b0;
					s_d.pfv  = 1'b0;
					s_d.pfw  = 1'b0;
					s_d.pbd  = s_q.st == ST_PROG ? 1'b0 : s_q.pbd;
					s_d.stat = `FBI_ST_OK;
					s_d.busy = 1'b0;
					s_d.st   = ST_IDLE;
				end
			end
			ST_OUT:
			begin
				s_d.busy = 1'b0;
				s_d.st   = ST_IDLE;
			end
			default:
			begin
				s_d.busy = 1'b0;
				s_d.st   = ST_IDLE;
			end
		endcase
		if (dlv)
		begin
			s_d.bb   = dlv_d;
			s_d.bba  = s_q.ra;
			s_d.bbv  = 1'b1;
			s_d.bbs  = dlv_s;
			s_d.rd   = fbi_word(dlv_d, s_q.rw);
			s_d.stat = dlv_s;
			s_d.pfw  = s_q.r_seq;
			// Six-cycle variant holds busy one extra cycle
			s_d.busy = s_q.r_m6;
			s_d.st   = s_q.r_m6 ? ST_OUT : ST_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
		begin
			s_q      <= '0;
			s_q.st   <= ST_IDLE;
			s_q.cmd  <= CM_NONE;
			s_q.stat <= `FBI_ST_OK;
		end
		else
			s_q <= s_d;

	assign o_rd_data = s_q.rd;
	assign o_busy    = s_q.busy;
	assign o_status  = s_q.stat;

	// ****************************************
	// Checks
	// ****************************************
	always_ff @(posedge i_clk or negedge rst_n)
		if (!rst_n)
			bsy_cnt <= 4'h0;
		else if (s_q.busy && s_q.cmd == CM_READ && bsy_cnt != 4'hf)
			bsy_cnt <= bsy_cnt + 4'h1;
		else if (!s_q.busy)
			bsy_cnt <= 4'h0;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!rst_n);

	a_read_busy_bound: assert property (bsy_cnt <= `FBI_BUSY_MAX)
		else $error("read busy longer than nine cycles");
	a_read_dbl_code: assert property (s_q.st == ST_FETCH && fdone && dec_dbl
		|=> o_status == `FBI_ST_DBL)
		else $error("double error not reported as 10");
	a_read_sgl_code: assert property (s_q.st == ST_FETCH && fdone && dec_sgl
		|=> o_status == `FBI_ST_SGL)
		else $error("single error not reported as 01");
	a_prog_clean_buf: assert property (disp && s_q.cmd == CM_PROG && !s_q.pbd
		|=> o_status == `FBI_ST_SGL && !o_busy)
		else $error("clean program not reported as 01");
	a_write_other_page: assert property (disp && s_q.cmd == CM_WRITE && !same_pg
		&& s_q.pbv && s_q.pbd |=> o_status == `FBI_ST_FAIL)
		else $error("write to other page not reported as 11");
	a_six_cycle_tail: assert property (s_q.st == ST_OUT |-> o_busy ##1 !o_busy)
		else $error("six-cycle read tail wrong");
	a_prefetch_target: assert property (s_q.st == ST_IDLE && cmd_in == CM_NONE
		&& s_q.pfw && !s_q.f_act |=> s_q.f_act && s_q.fa == $past(nxt))
		else $error("prefetch not aimed at look-ahead address");
	a_sector_wrap: assert property (s_q.bba.sect == `FBI_LAST_SECT
		&& s_q.bba.page == `FBI_SPARE_PG |-> nxt.sect == 6'h00)
		else $error("look-ahead did not wrap to sector zero");
	a_unlock_fill: assert property (s_q.st == ST_COPY && fdone
		&& s_q.uc == `FBI_AUX_BLK |=> s_q.pbv && !o_busy)
		else $error("unlock did not load page buffer");
	a_write_stores: assert property (disp && s_q.cmd == CM_WRITE && same_pg
		|=> fbi_word(s_q.pb[$past(s_q.ra.blk)], $past(s_q.rw)) == $past(s_q.wd))
		else $error("buffer word not stored");

	c_prefetch_hit: cover property (disp && s_q.cmd == CM_READ && s_q.pfv
		&& s_q.pfa == s_q.ra);
	c_mispredict: cover property (s_q.st == ST_WAIT && s_q.f_act && s_q.cmd == CM_READ);
	c_six_cycle: cover property (s_q.st == ST_OUT);
	c_program_done: cover property (s_q.st == ST_PROG && s_q.uc == `FBI_AUX_BLK);
endmodule // fbi_flash_if

//--- verification/fbi_user_model.sv
// Fabric-side command issuer facing the flash block interface
`timescale 1ns/1ps
module fbi_user_model
	import fbi_pkg::*;
(
	input  wire logic     i_busy,
	input  wire logic     i_go,
	input  wire fbi_cmd_t i_cmd,
	output logic [5:0]    o_req
);
	// ****************************************
	// Request decode
	// ****************************************
	// Suppressed while busy, so a command issued then is dropped; go lasts one cycle
	always_comb
	begin
		o_req = 6'h00;
		if (i_go && !i_busy && i_cmd != CM_NONE)
			o_req = 6'h01 << (int'(i_cmd) - 1);
	end
endmodule // fbi_user_model

//--- verification/tb.sv
// Self-checking bench of the flash block interface
`timescale 1ns/1ps
module tb;
	import fbi_pkg::*;
	typedef struct {
		fbi_cmd_t c;
		logic [5:0] s, p;
		logic [2:0] b;
		logic [1:0] w;
		logic [31:0] d;
		logic [4:0] f;
		logic [1:0] st;
	} fbi_row_t;
	logic        clk, arst_n, go, spare, aux, seq, six, lock;
	logic [5:0]  sect, page, req;
	logic [2:0]  blk;
	logic [1:0]  word, stat;
	logic [31:0] wd, rd;
	logic        busy;
	fbi_cmd_t    cmd;
	int          fails, checks, nb;
	// Flags are {spare, aux, seq, six, lock}
	fbi_row_t rows[18] = '{
		'{CM_ERASE, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00, 2'h0},
		'{CM_ERASE, 6'h00, 6'h01, 3'h0, 2'h0, 32'h0, 5'h00, 2'h0},
		'{CM_ERASE, 6'h01, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00, 2'h0},
		'{CM_ERASE, 6'h3f, 6'h00, 3'h0, 2'h0, 32'h0, 5'h10, 2'h0},
		'{CM_ERASE, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h10, 2'h0},
		'{CM_UNLOCK, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00, 2'h0},
		'{CM_WRITE, 6'h00, 6'h00, 3'h0, 2'h0, 32'h12345678, 5'h00, 2'h0},
		'{CM_WRITE, 6'h00, 6'h00, 3'h7, 2'h3, 32'h9abcdef0, 5'h00, 2'h0},
		'{CM_WRITE, 6'h00, 6'h01, 3'h0, 2'h0, 32'h1, 5'h00, 2'h3},
		'{CM_PROG, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h01, 2'h0},
		'{CM_PROG, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00, 2'h1},
		'{CM_READ, 6'h00, 6'h00, 3'h0, 2'h0, 32'h12345678, 5'h00, 2'h0},
		'{CM_READ, 6'h00, 6'h00, 3'h7, 2'h3, 32'h9abcdef0, 5'h00, 2'h0},
		'{CM_READ, 6'h00, 6'h01, 3'h0, 2'h0, 32'h0, 5'h00, 2'h0},
		'{CM_DROP, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00, 2'h0},
		'{CM_ERASE, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00, 2'h1},
		'{CM_WRITE, 6'h00, 6'h00, 3'h1, 2'h0, 32'h5, 5'h00, 2'h1},
		'{CM_READ, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h08, 2'h0}
	};

	fbi_user_model i_fbi_user_model (
		.i_busy (busy),
		.i_go   (go),
		.i_cmd  (cmd),
		.o_req  (req)
	);

	fbi_flash_if i_fbi_flash_if (
		.i_clk              (clk),
		.i_arst_n           (arst_n),
		.i_sector           (sect),
		.i_page             (page),
		.i_block            (blk),
		.i_word             (word),
		.i_spare_page_sel   (spare),
		.i_extra_block_sel  (aux),
		.i_seq_prefetch_sel (seq),
		.i_six_cycle_mode   (six),
		.i_read_req         (req[0]),
		.i_buf_write_req    (req[1]),
		.i_write_word_in    (wd),
		.i_prog_req         (req[2]),
		.i_page_lock_set    (lock),
		.i_page_erase_req   (req[3]),
		.i_page_unlock_req  (req[4]),
		.i_buffer_drop_req  (req[5]),
		.o_rd_data          (rd),
		.o_busy             (busy),
		.o_status           (stat)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Issue one command, then count the cycles that busy stands
	task automatic run(input fbi_cmd_t c, input logic [5:0] s, p, input logic [2:0] b,
		input logic [1:0] w, input logic [31:0] d, input logic [4:0] f);
		int k;
		@(posedge clk);
		cmd <= c;
		{sect, page, blk, word, wd, go} <= {s, p, b, w, d, 1'b1};
		{spare, aux, seq, six, lock} <= f;
		@(posedge clk);
		go <= 1'b0;
		#1;
		k = 0;
		while (busy !== 1'b1 && k < 4)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		nb = 0;
		while (busy === 1'b1 && nb < 60)
		begin
			@(posedge clk);
			#1;
			nb++;
		end
		check("busy_timeout", 32'(k == 4 || nb == 60), 32'h0);
	endtask

	// Read with look-ahead, let the prefetch finish, then hit the predicted block
	task automatic ahead(input logic [5:0] s1, p1, input logic [2:0] b1, input logic [4:0] f1,
		input logic [5:0] s2, p2, input logic [2:0] b2, input logic [4:0] f2);
		run(CM_READ, s1, p1, b1, 2'h0, 32'h0, f1 | 5'h04);
		repeat (8) @(posedge clk);
		run(CM_READ, s2, p2, b2, 2'h0, 32'h0, f2);
		check("hit_busy", 32'(nb), 32'h1);
	endtask

	task automatic do_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check("busy", 32'(busy), 32'h0);
		check("status", 32'(stat), 32'h0);
		check("rd_data", rd, 32'h0);
	endtask

	// ****************************************
	// Stimulus
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		#1_000_000;
		fails++;
		final_report();
	end

	initial
	begin
		{arst_n, go, spare, aux, seq, six, lock, sect, page, blk, word, wd} = '0;
		cmd = CM_NONE;
		do_reset();
		foreach (rows[i])
		begin
			run(rows[i].c, rows[i].s, rows[i].p, rows[i].b, rows[i].w, rows[i].d, rows[i].f);
			check("status", 32'(stat), 32'(rows[i].st));
			if (rows[i].c == CM_READ)
				check("rd_data", rd, rows[i].d);
		end
		run(CM_READ, 6'h00, 6'h01, 3'h3, 2'h0, 32'h0, 5'h00);
		check("miss_busy5", 32'(nb), 32'h4);
		run(CM_READ, 6'h00, 6'h01, 3'h5, 2'h0, 32'h0, 5'h02);
		check("miss_busy6", 32'(nb), 32'h5);
		ahead(6'h00, 6'h00, 3'h6, 5'h00, 6'h00, 6'h00, 3'h7, 5'h00);
		ahead(6'h00, 6'h00, 3'h7, 5'h00, 6'h00, 6'h01, 3'h0, 5'h00);
		ahead(6'h3f, 6'h00, 3'h0, 5'h10, 6'h00, 6'h00, 3'h0, 5'h10);
		ahead(6'h00, 6'h00, 3'h0, 5'h08, 6'h00, 6'h01, 3'h0, 5'h08);
		// Second read lands while the prefetch of block 1 is still running
		run(CM_READ, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h04);
		run(CM_READ, 6'h00, 6'h01, 3'h4, 2'h0, 32'h0, 5'h00);
		check("late_busy", 32'(nb <= 9), 32'h1);
		check("late_data", rd, 32'h0);
		// Wear the page out; per-program status may flip near the limit
		for (int i = 0; i < 1000; i++)
		begin
			run(CM_WRITE, 6'h01, 6'h00, 3'h0, 2'h0, 32'(i), 5'h00);
			run(CM_PROG, 6'h01, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00);
		end
		run(CM_WRITE, 6'h01, 6'h00, 3'h0, 2'h0, 32'h7, 5'h00);
		run(CM_PROG, 6'h01, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00);
		check("worn_prog", 32'(stat), 32'h3);
		run(CM_ERASE, 6'h01, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00);
		check("worn_erase", 32'(stat), 32'h3);
		do_reset();
		run(CM_ERASE, 6'h00, 6'h00, 3'h0, 2'h0, 32'h0, 5'h00);
		check("unlocked", 32'(stat), 32'h0);
		final_report();
	end
endmodule // tb
